// >>> common/dsuc_cfg.svh
// Constants of the serial converter control block.
// Assumes inclusion by bare name from the package and modules.
// Behaviour
// - Clear input acts on its falling edge, independent of serial clock.
// - Clear sets input and converter registers to zero.
// - Load falling edge copies input register into converter register.
// - Load low, or low at 16th edge, updates converter with new data.
// - Over-temperature powers analog down; serial logic keeps running.
// - Entering shutdown sets thermal flag bit 0 and drives alarm low.
// - Shutdown, flag and alarm persist until host writes flag to zero.
// - Serial port writes only input and control; converter is hidden.
// - Frame is 16 bits MSB first: read/write, 3 address, 12 data.
// - Write has read/write 0; address 001 input, 111 control.
// - Frame starts on sync low; input shifts on falling serial clock.
// - On 16th falling edge the addressed operation executes at once.
// - Serial clock may toggle only during frames.
// - Readback works for input and control registers.
// - Read frame shifts register out on the next 12 clocks.
// - Serial output floats until fifth rising edge, then drives.
// - Power-on sets control to 0x40, input and converter to zero.
// - Address 000 is a no-operation frame changing nothing.
// - Control bit 2 powers channel up when 1, down when 0.
// - Control bit 6: 1 floats powered-down output, 0 grounds it.
`ifndef DSUC_CFG_SVH
`define DSUC_CFG_SVH
`define DSUC_FRAME_BITS 16
`define DSUC_DATA_BITS 12
`define DSUC_SEL_NOP 3'h0
`define DSUC_SEL_INPUT 3'h1
`define DSUC_SEL_CTRL 3'h7
`define DSUC_CTRL_RESET 7'h40
`define DSUC_DATA_RESET 12'h000
`define DSUC_BIT_THERMAL 0
`define DSUC_BIT_POWER 2
`define DSUC_BIT_FLOAT 6
`define DSUC_DRIVE_EDGE 5'h05
`define DSUC_LAST_EDGE 5'h10
`endif

// >>> common/dsuc_pkg.sv
// Types of the serial converter control block.
// Assumes dsuc_cfg.svh is on the include path.
`include "dsuc_cfg.svh"
package dsuc_pkg;
  typedef logic [`DSUC_DATA_BITS-1:0] dsuc_data_t;
  typedef logic [6:0] dsuc_ctrl_t;
  typedef enum logic [1:0] {
    DSUC_IDLE = 2'b00,
    DSUC_SHIFT = 2'b01,
    DSUC_DONE = 2'b10
  } dsuc_state_e;
  // Analog-facing status gathered in one carrier
  typedef struct packed {
    logic powered;
    logic float_out;
    logic ground_out;
  } dsuc_analog_s;
endpackage : dsuc_pkg

// >>> dv/dsuc_core_assertions.sv
// Concurrent checks on the converter control core ports.
// Assumes binding into dsuc_core with a 100 MHz mclk.
`timescale 1ns/1ns
module dsuc_core_assertions #(
  parameter int FRAME_BITS = 16,
  parameter int DATA_BITS = 12
) (
  // Clock
  input wire logic mclk,
  input wire logic sys_rst,
  // Pins
  input wire logic sync_n,
  input wire logic sclk,
  input wire logic sdi,
  input wire logic sdo_o,
  input wire logic sdo_oe_n,
  input wire logic load_output_n,
  input wire logic async_clear_n,
  input wire logic over_temp,
  input wire logic alarm_n,
  // Analog
  input wire dsuc_pkg::dsuc_data_t converter_code,
  input wire dsuc_pkg::dsuc_analog_s analog,
  input wire dsuc_pkg::dsuc_ctrl_t control_word
);
  import dsuc_pkg::*;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  a_heat_alarm: assert property (
    over_temp [*6] |-> !alarm_n) else $error("alarm late");
  a_flag_alarm: assert property (
    $fell(alarm_n) |-> ##[0:2] control_word[0]) else $error("flag late");
  a_alarm_sticks: assert property (
    $rose(alarm_n) |-> !$past(sync_n, 2)) else $error("alarm freed");
  a_shutdown_off: assert property (
    !alarm_n |-> !analog.powered) else $error("powered in shutdown");
  a_power_bit: assert property (
    (alarm_n && !control_word[0]) |-> analog.powered == control_word[2])
    else $error("power bit ignored");
  a_float_sel: assert property (
    !analog.powered |-> analog.float_out == control_word[6] &&
    analog.ground_out == !control_word[6]) else $error("float select");
  a_sdo_idle: assert property (
    sync_n [*5] |-> sdo_oe_n) else $error("sdo driven outside frame");
  a_clear_zero: assert property (
    $fell(async_clear_n) |-> ##[2:8] converter_code == '0)
    else $error("clear ignored");
  a_ctrl_reserved: assert property (
    control_word[5:3] == '0 && !control_word[1]) else $error("reserved set");
  a_ctrl_quiet: assert property (
    sync_n [*6] |-> $stable(control_word[6:1])) else $error("ctrl moved");
  cover property ($fell(sdo_oe_n));
  cover property ($fell(alarm_n));
  cover property ($fell(async_clear_n));
  cover property ($rose(analog.powered));
endmodule : dsuc_core_assertions

bind dsuc_core dsuc_core_assertions #(
  .FRAME_BITS(FRAME_BITS),
  .DATA_BITS(DATA_BITS)
) u_chk (
  .mclk(mclk), .sys_rst(sys_rst), .sync_n(sync_n), .sclk(sclk),
  .sdi(sdi), .sdo_o(sdo_o), .sdo_oe_n(sdo_oe_n),
  .load_output_n(load_output_n), .async_clear_n(async_clear_n),
  .over_temp(over_temp), .alarm_n(alarm_n),
  .converter_code(converter_code), .analog(analog),
  .control_word(control_word)
);

// >>> dv/dsuc_host.sv
// Serial host model: frames words into the core, gathers read-back.
// Assumes 100 MHz mclk; one serial clock period is 16 mclk cycles.
`timescale 1ns/1ns
module dsuc_host (
  // Clock
  input wire logic mclk,
  // Serial pins
  output logic sync_n,
  output logic sclk,
  output logic sdi,
  input wire logic sdo_o,
  input wire logic sdo_oe_n
);
  initial begin
    sync_n = 1'b1;
    sclk = 1'b0;
    sdi = 1'b0;
  end

  task automatic half();
    repeat (8) @(posedge mclk);
  endtask : half

  // Sends the top nbits of w; a short count aborts the frame
  task automatic xfer(input logic [15:0] w, input int nbits,
                      output logic [11:0] rd);
    rd = '0;
    sync_n <= 1'b0;
    half();
    for (int i = 15; i > 15 - nbits; i--) begin
      sclk <= 1'b1;
      sdi <= w[i];
      half();
      sclk <= 1'b0;
      half();
      if (i < 12) rd[i] = sdo_oe_n ? 1'bz : sdo_o;
    end
    // Clock parks low between frames; released data shows a changed level
    sclk <= 1'b0;
    sdi <= ~sdi;
    half();
    sync_n <= 1'b1;
    half();
  endtask : xfer
endmodule : dsuc_host

// >>> dv/tb.sv
// Self-checking bench for the converter control core.
// Assumes dsuc_host as serial host and the bound checker.
`timescale 1ns/1ns
module tb;
  import dsuc_pkg::*;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic load_output_n = 1'b1;
  logic async_clear_n = 1'b1;
  logic over_temp = 1'b0;
  logic sync_n, sclk, sdi, sdo_o, sdo_oe_n, alarm_n;
  dsuc_data_t converter_code;
  dsuc_analog_s analog;
  dsuc_ctrl_t control_word;
  logic [11:0] rd;
  int n_fail = 0;
  int cmp_count = 0;

  always #5 mclk = ~mclk;

  dsuc_core i_dsuc_core (
    .mclk(mclk), .sys_rst(sys_rst), .sync_n(sync_n), .sclk(sclk),
    .sdi(sdi), .sdo_o(sdo_o), .sdo_oe_n(sdo_oe_n),
    .load_output_n(load_output_n), .async_clear_n(async_clear_n),
    .over_temp(over_temp), .alarm_n(alarm_n),
    .converter_code(converter_code), .analog(analog),
    .control_word(control_word)
  );
  dsuc_host host_m (.mclk(mclk), .sync_n(sync_n), .sclk(sclk), .sdi(sdi),
    .sdo_o(sdo_o), .sdo_oe_n(sdo_oe_n));

  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [2:0] sel, input logic [11:0] d);
    host_m.xfer({1'b0, sel, d}, 16, rd);
  endtask : wr

  task automatic rb(input logic [2:0] sel);
    host_m.xfer({1'b1, sel, 12'h000}, 16, rd);
  endtask : rb

  task automatic t_reset();
    chk(converter_code, 12'h000);
    chk({5'h00, control_word}, 12'h040);
    chk({9'h000, analog}, 12'h002);
    rb(3'h7);
    chk(rd, 12'h040);
    rb(3'h1);
    chk(rd, 12'h000);
  endtask : t_reset

  task automatic t_load();
    wr(3'h1, 12'ha5c);
    chk(converter_code, 12'h000);
    rb(3'h1);
    chk(rd, 12'ha5c);
    load_output_n <= 1'b0;
    repeat (8) @(posedge mclk);
    chk(converter_code, 12'ha5c);
    wr(3'h1, 12'h3c1);
    chk(converter_code, 12'h3c1);
    load_output_n <= 1'b1;
  endtask : t_load

  task automatic t_refuse();
    for (int s = 0; s < 7; s++) begin
      if (s != 1) wr(3'(s), 12'hfff);
    end
    host_m.xfer(16'h1555, 10, rd);
    rb(3'h1);
    chk(rd, 12'h3c1);
    chk(converter_code, 12'h3c1);
    rb(3'h3);
    chk(rd, 12'h000);
  endtask : t_refuse

  task automatic t_ctrl();
    wr(3'h7, 12'h07e);
    wr(3'h0, 12'h000);
    chk({5'h00, control_word}, 12'h044);
    chk({9'h000, analog}, 12'h004);
    wr(3'h7, 12'h000);
    wr(3'h0, 12'h000);
    chk({9'h000, analog}, 12'h001);
    chk(converter_code, 12'h3c1);
    wr(3'h7, 12'h044);
    wr(3'h0, 12'h000);
  endtask : t_ctrl

  task automatic t_heat();
    over_temp <= 1'b1;
    repeat (10) @(posedge mclk);
    chk({11'h000, alarm_n}, 12'h000);
    chk({5'h00, control_word}, 12'h045);
    chk({9'h000, analog}, 12'h002);
    over_temp <= 1'b0;
    repeat (10) @(posedge mclk);
    rb(3'h7);
    chk(rd, 12'h045);
    chk({11'h000, alarm_n}, 12'h000);
    wr(3'h7, 12'h044);
    wr(3'h0, 12'h000);
    chk({11'h000, alarm_n}, 12'h001);
    chk({9'h000, analog}, 12'h004);
  endtask : t_heat

  task automatic t_clear();
    async_clear_n <= 1'b0;
    repeat (8) @(posedge mclk);
    chk(converter_code, 12'h000);
    rb(3'h1);
    chk(rd, 12'h000);
    // A held-low clear must not block later writes
    wr(3'h1, 12'h7e7);
    rb(3'h1);
    chk(rd, 12'h7e7);
    async_clear_n <= 1'b1;
  endtask : t_clear

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : final_report

  initial begin
    repeat (20) @(posedge mclk);
    sys_rst <= 1'b0;
    repeat (6) @(posedge mclk);
    t_reset();
    t_load();
    t_refuse();
    t_ctrl();
    t_heat();
    t_clear();
    final_report();
  end

  // 26 frames of up to 280 cycles each; allow over twice that
  initial begin
    #200000;
    n_fail++;
    final_report();
  end
endmodule : tb

// >>> hw/dsuc_core.sv
// Serial control section of a 12-bit converter.
// Assumes all pins asynchronous to mclk; serial clock far below mclk/4.
`timescale 1ns/1ns
`include "dsuc_cfg.svh"
module dsuc_core #(
  parameter int FRAME_BITS = `DSUC_FRAME_BITS,
  parameter int DATA_BITS = `DSUC_DATA_BITS
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Serial port pins
  input wire logic sync_n,
  input wire logic sclk,
  input wire logic sdi,
  output logic sdo_o,
  output logic sdo_oe_n,
  // Update and clear pins
  input wire logic load_output_n,
  input wire logic async_clear_n,
  // Thermal sensor level, high while die is over temperature
  input wire logic over_temp,
  output logic alarm_n,
  // Analog side
  output dsuc_pkg::dsuc_data_t converter_code,
  output dsuc_pkg::dsuc_analog_s analog,
  output dsuc_pkg::dsuc_ctrl_t control_word
);
  import dsuc_pkg::*;

  initial begin
    if (FRAME_BITS != 16 || DATA_BITS != 12)
      $error("Frame layout supports 16-bit words with 12 data bits only");
    if (`DSUC_LAST_EDGE != FRAME_BITS)
      $error("Last edge count must match the frame length");
    if (`DSUC_DRIVE_EDGE >= `DSUC_LAST_EDGE)
      $error("Read-back must begin before the last edge");
  end

  logic [4:0] pins_s;
  logic sync_s;
  logic sclk_s;
  logic sdi_s;
  logic load_s;
  logic clr_s;
  logic sclk_rise;
  logic sclk_fall;
  logic sync_fall;
  logic sync_rise;
  logic load_fall;
  logic clr_fall;
  logic temp_s;

  // All pins cross into mclk before any decode; reset levels equal the idle
  // pins (sclk and sdi rest low) so no false edge follows reset
  dsuc_sync #(.WIDTH(5), .INIT(5'h13)) u_sync_pins (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .din({sync_n, sclk, sdi, load_output_n, async_clear_n}),
    .dout(pins_s)
  );
  dsuc_sync #(.WIDTH(1), .INIT(1'b0)) u_sync_temp (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .din(over_temp),
    .dout(temp_s)
  );
  assign {sync_s, sclk_s, sdi_s, load_s, clr_s} = pins_s;

  dsuc_edge #(.INIT(1'b0)) u_edge_sclk (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .level(sclk_s),
    .rise(sclk_rise),
    .fall(sclk_fall)
  );
  dsuc_edge #(.INIT(1'b1)) u_edge_sync (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .level(sync_s),
    .rise(sync_rise),
    .fall(sync_fall)
  );
  dsuc_edge #(.INIT(1'b1)) u_edge_load (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .level(load_s),
    .rise(),
    .fall(load_fall)
  );
  dsuc_edge #(.INIT(1'b1)) u_edge_clr (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .level(clr_s),
    .rise(),
    .fall(clr_fall)
  );

  // Decoding of the register select field, used for writes and reads
  function automatic logic sel_is(input logic [2:0] sel,
                                  input logic [2:0] code);
    sel_is = (sel == code);
  endfunction : sel_is

  // Control write keeps the power and float bits; reserved bits stay zero
  // and the flag can only be cleared, so a stray 1 never fakes an alarm
  function automatic dsuc_ctrl_t ctrl_merge(input dsuc_ctrl_t old_v,
                                            input dsuc_data_t wdata);
    ctrl_merge = '0;
    ctrl_merge[`DSUC_BIT_FLOAT] = wdata[`DSUC_BIT_FLOAT];
    ctrl_merge[`DSUC_BIT_POWER] = wdata[`DSUC_BIT_POWER];
    ctrl_merge[`DSUC_BIT_THERMAL] = old_v[`DSUC_BIT_THERMAL]
                                    & wdata[`DSUC_BIT_THERMAL];
  endfunction : ctrl_merge

  // Read-back source; the converter register has no address of its own
  function automatic dsuc_data_t readback(input logic [2:0] sel,
                                          input dsuc_ctrl_t ctrl_v,
                                          input dsuc_data_t in_v);
    readback = '0;
    if (sel_is(sel, `DSUC_SEL_CTRL)) begin
      readback = {5'h00, ctrl_v};
    end
    if (sel_is(sel, `DSUC_SEL_INPUT)) begin
      readback = in_v;
    end
  endfunction : readback

  // Frame state
  dsuc_state_e state_q, state_d;
  logic [15:0] shift_q, shift_d;
  logic [4:0] fall_cnt_q, fall_cnt_d;
  logic [4:0] rise_cnt_q, rise_cnt_d;
  logic read_q, read_d;
  logic [2:0] rsel_q, rsel_d;
  logic [11:0] rdata_q, rdata_d;
  logic sdo_q, sdo_d;
  logic sdo_en_q, sdo_en_d;

  // Register state
  dsuc_data_t input_q, input_d;
  dsuc_data_t conv_q, conv_d;
  dsuc_ctrl_t ctrl_q, ctrl_d;
  logic shutdown_q, shutdown_d;

  logic [15:0] word;
  logic frame_end;
  logic wr_input;
  logic wr_ctrl;

  always_comb begin
    state_d = state_q;
    shift_d = shift_q;
    fall_cnt_d = fall_cnt_q;
    rise_cnt_d = rise_cnt_q;
    read_d = read_q;
    rsel_d = rsel_q;
    rdata_d = rdata_q;
    sdo_d = sdo_q;
    sdo_en_d = sdo_en_q;
    word = {shift_q[14:0], sdi_s};
    frame_end = 1'b0;
    case (state_q)
      DSUC_IDLE: begin
        if (sync_fall) begin
          state_d = DSUC_SHIFT;
          fall_cnt_d = 5'h00;
          rise_cnt_d = 5'h00;
          read_d = 1'b0;
        end
      end
      DSUC_SHIFT: begin
        if (sync_rise) begin
          state_d = DSUC_IDLE;
          sdo_en_d = 1'b0;
        end else begin
          if (sclk_fall) begin
            shift_d = word;
            fall_cnt_d = fall_cnt_q + 5'h01;
            if (fall_cnt_q == 5'h03) begin
              read_d = shift_q[2];
              rsel_d = {shift_q[1:0], sdi_s};
            end
            if (fall_cnt_q + 5'h01 == `DSUC_LAST_EDGE) begin
              frame_end = 1'b1;
              state_d = DSUC_DONE;
            end
            // Read data leaves MSB first on the falling edges
            if (read_q && fall_cnt_q >= 5'h04) begin
              sdo_d = rdata_q[11];
              rdata_d = {rdata_q[10:0], 1'b0};
            end
          end
          if (sclk_rise) begin
            rise_cnt_d = rise_cnt_q + 5'h01;
            if (rise_cnt_q + 5'h01 == `DSUC_DRIVE_EDGE && read_q) begin
              sdo_en_d = 1'b1;
              rdata_d = readback(rsel_q, ctrl_q, input_q);
              sdo_d = 1'b0;
            end
          end
        end
      end
      DSUC_DONE: begin
        // Clocks past the frame release the output at their first rise
        if (sclk_rise) begin
          sdo_en_d = 1'b0;
        end
        if (sync_rise) begin
          state_d = DSUC_IDLE;
          sdo_en_d = 1'b0;
        end
      end
      default: begin
        state_d = DSUC_IDLE;
        sdo_en_d = 1'b0;
      end
    endcase
    if (sys_rst) begin
      state_d = DSUC_IDLE;
      shift_d = 16'h0000;
      fall_cnt_d = 5'h00;
      rise_cnt_d = 5'h00;
      read_d = 1'b0;
      rsel_d = 3'h0;
      rdata_d = 12'h000;
      sdo_d = 1'b0;
      sdo_en_d = 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    state_q <= state_d;
    shift_q <= shift_d;
    fall_cnt_q <= fall_cnt_d;
    rise_cnt_q <= rise_cnt_d;
    read_q <= read_d;
    rsel_q <= rsel_d;
    rdata_q <= rdata_d;
    sdo_q <= sdo_d;
    sdo_en_q <= sdo_en_d;
  end

  // Only writes to 001 and 111 act; 000 and reserved codes fall through
  assign wr_input = frame_end & ~word[15]
                    & sel_is(word[14:12], `DSUC_SEL_INPUT);
  assign wr_ctrl = frame_end & ~word[15]
                   & sel_is(word[14:12], `DSUC_SEL_CTRL);

  always_comb begin
    input_d = input_q;
    conv_d = conv_q;
    ctrl_d = ctrl_q;
    shutdown_d = shutdown_q;
    if (wr_input) begin
      input_d = word[11:0];
      if (!load_s) begin
        conv_d = word[11:0];
      end
    end
    if (load_fall) begin
      conv_d = wr_input ? word[11:0] : input_q;
    end
    if (wr_ctrl) begin
      ctrl_d = ctrl_merge(ctrl_q, word[11:0]);
      shutdown_d = shutdown_q & word[`DSUC_BIT_THERMAL];
    end
    // A new over-temperature wins over a clearing write
    if (temp_s) begin
      shutdown_d = 1'b1;
      ctrl_d[`DSUC_BIT_THERMAL] = 1'b1;
    end
    if (clr_fall) begin
      input_d = `DSUC_DATA_RESET;
      conv_d = `DSUC_DATA_RESET;
    end
    if (sys_rst) begin
      input_d = `DSUC_DATA_RESET;
      conv_d = `DSUC_DATA_RESET;
      ctrl_d = `DSUC_CTRL_RESET;
      shutdown_d = 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    input_q <= input_d;
    conv_q <= conv_d;
    ctrl_q <= ctrl_d;
    shutdown_q <= shutdown_d;
  end

  // Shutdown behaves like the power-down bit; code register untouched
  always_comb begin
    analog.powered = ctrl_q[`DSUC_BIT_POWER] & ~shutdown_q;
    analog.float_out = ~analog.powered & ctrl_q[`DSUC_BIT_FLOAT];
    analog.ground_out = ~analog.powered & ~ctrl_q[`DSUC_BIT_FLOAT];
  end

  assign converter_code = conv_q;
  assign control_word = ctrl_q;
  assign alarm_n = ~shutdown_q;
  assign sdo_o = sdo_q;
  assign sdo_oe_n = ~sdo_en_q;
endmodule : dsuc_core

// >>> hw/dsuc_edge.sv
// Edge detector on a synchronised level.
// Assumes input already on mclk; pulses last one cycle.
`timescale 1ns/1ns
module dsuc_edge #(
  parameter logic INIT = 1'b1
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Level in, pulses out
  input wire logic level,
  output logic rise,
  output logic fall
);
  logic last_q;
  logic last_d;
  always_comb begin
    last_d = sys_rst ? INIT : level;
  end
  always_ff @(posedge mclk) begin
    last_q <= last_d;
  end
  assign rise = ~sys_rst & level & ~last_q;
  assign fall = ~sys_rst & ~level & last_q;
endmodule : dsuc_edge

// >>> hw/dsuc_sync.sv
// Two-stage synchroniser for pin inputs.
// Assumes async inputs; output is a plain level on mclk.
`timescale 1ns/1ns
module dsuc_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Data
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] meta_d;
  logic [WIDTH-1:0] sync_q;
  logic [WIDTH-1:0] sync_d;
  initial begin
    if (WIDTH < 1) $error("WIDTH must be positive");
  end
  always_comb begin
    meta_d = sys_rst ? INIT : din;
    sync_d = sys_rst ? INIT : meta_q;
  end
  always_ff @(posedge mclk) begin
    meta_q <= meta_d;
    sync_q <= sync_d;
  end
  assign dout = sync_q;
endmodule : dsuc_sync
